// ---- inc/dac_cmd_pkg.sv ----
// Overview of operation
// - A toggle/dither enable command stores sixteen bits, and a set bit turns toggle/dither on for its channel.
// - A cleared enable bit turns toggle/dither off for its channel, and every enable bit resets to zero.
// - The monitor multiplexer control carries an enable at bit 18, and the monitor output is driven only while it is one.
// - The monitor multiplexer control also carries a select field that picks the monitored signal and resets to zero.
// - A read/write fault register holds thermal shutdown at bit 10, clock integrity at bit 9 and command integrity at bit 8, all reset to zero.
// - The broadcast code command loads the code into every channel's input register without updating any output.
// - The broadcast code-and-update command loads each channel's bank-selected input register and moves the code into every DAC register at once.
// - The broadcast settings command applies one 12-bit settings field, in the single-channel layout, to every channel.
// - The broadcast settings-and-update command applies the settings to every channel and also updates every DAC register.
// - The global update command copies each channel's input register into its DAC register for all channels together.
// - Per-channel reads return, for a 4-bit channel index, the adjusted code, the settings, the offset adjust or the gain adjust.
// - Global reads return configuration, power-down, bank select, soft toggle, enables, mux control, faults and thermal status, and 0xff does nothing.
// - Each channel's input bank select bit sends code writes to the first input register when clear and to the second when set.
// - A falling soft toggle bit updates the channel from its first input register and a rising one from its second.
package dac_cmd_pkg;

	// ------------------------------------------------------------------
	// Command bytes
	// ------------------------------------------------------------------
	localparam logic [7:0] CMD_BANK_SELECT = 8'h72;
	localparam logic [7:0] CMD_SOFT_TOGGLE = 8'h73;
	localparam logic [7:0] CMD_TOGGLE_EN = 8'h74;
	localparam logic [7:0] CMD_MUX_CTRL = 8'h75;
	localparam logic [7:0] CMD_FAULT = 8'h76;
	localparam logic [7:0] CMD_CODE_ALL = 8'h78;
	localparam logic [7:0] CMD_CODE_ALL_UPD = 8'h79;
	localparam logic [7:0] CMD_SET_ALL = 8'h7a;
	localparam logic [7:0] CMD_SET_ALL_UPD = 8'h7b;
	localparam logic [7:0] CMD_UPDATE_ALL = 8'h7c;
	localparam logic [7:0] CMD_RD_CONFIG = 8'hf0;
	localparam logic [7:0] CMD_RD_POWER = 8'hf1;
	localparam logic [7:0] CMD_RD_BANK = 8'hf2;
	localparam logic [7:0] CMD_RD_TOGGLE = 8'hf3;
	localparam logic [7:0] CMD_RD_ENABLE = 8'hf4;
	localparam logic [7:0] CMD_RD_MUX = 8'hf5;
	localparam logic [7:0] CMD_RD_FAULT = 8'hf6;
	localparam logic [7:0] CMD_RD_THERMAL = 8'hf7;
	localparam logic [7:0] CMD_NOP = 8'hff;

	// Upper nibble of per-channel reads.
	localparam logic [3:0] CMD_RD_CODE = 4'h8;
	localparam logic [3:0] CMD_RD_SET = 4'h9;
	localparam logic [3:0] CMD_RD_OFFSET = 4'ha;
	localparam logic [3:0] CMD_RD_GAIN = 4'hb;

	// ------------------------------------------------------------------
	// Field layout, relative to frame bit 8 (data field holds bits 23:8)
	// ------------------------------------------------------------------
	localparam int FIELD_BASE = 8;
	localparam int MUX_ON_BIT = 18 - FIELD_BASE;
	localparam int MUX_SEL_LSB = 8 - FIELD_BASE;
	localparam int MUX_SEL_W = 17 - 8 + 1;
	localparam int FAULT_LSB = 8 - FIELD_BASE;
	localparam int FAULT_W = 10 - 8 + 1;
	localparam int SET_W = 19 - 8 + 1;
	localparam int OFFSET_W = 23 - 10 + 1;
	localparam int DATA_W = 23 - 8 + 1;
	localparam int CONFIG_W = 10 - 8 + 1;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [15:0] RST_ENABLE = 16'h0000;
	localparam logic [MUX_SEL_W-1:0] RST_MUX_SEL = 10'h000;
	localparam logic [FAULT_W-1:0] RST_FAULT = 3'h0;
	localparam logic [SET_W-1:0] RST_SET = 12'h000;

endpackage

// ---- verilog/dac_broadcast_command_decoder.sv ----
`timescale 1ns/1ns
module dac_broadcast_command_decoder
#(
	parameter int CHANNELS = 16,
	parameter int DAC_BITS = 16
)
(
	input wire logic clock, // 25 MHz system clock
	input wire logic nrst, // Asynchronous reset, active low
	input wire logic cmd_valid, // One-cycle strobe: a whole command is here
	input wire logic [7:0] cmd_byte, // Command byte of the frame
	input wire logic [15:0] cmd_data, // Frame bits 23 to 8
	input wire logic [2:0] config_in, // Configuration bits 10 to 8
	input wire logic [CHANNELS-1:0] power_down_in, // Power-down status
	input wire logic [CHANNELS-1:0] thermal_status_in, // Thermal status
	input wire logic [2:0] fault_event, // Fault set pulses, bit order as reg
	input wire logic [CHANNELS*14-1:0] offset_flat, // Offset adjust values
	input wire logic [CHANNELS*DAC_BITS-1:0] gain_flat, // Gain adjust values
	output logic [CHANNELS-1:0] toggle_dither_on, // Toggle/dither enables
	output logic monitor_mux_on, // Monitor multiplexer drives its pin
	output logic [9:0] monitor_select, // Monitored signal select
	output logic thermal_shutdown_fault, // Fault flag, bit 10
	output logic clock_integrity_fault, // Fault flag, bit 9
	output logic command_integrity_fault, // Fault flag, bit 8
	output logic [CHANNELS-1:0] input_bank_select, // Bank steering per channel
	output logic [CHANNELS-1:0] soft_toggle_bit, // Software toggle bits
	output logic [CHANNELS*DAC_BITS-1:0] dac_code_flat, // DAC registers
	output logic [CHANNELS*12-1:0] settings_flat, // Channel settings
	output logic [CHANNELS-1:0] dac_update, // One-cycle update pulses
	output logic rd_valid, // One-cycle strobe with read data
	output logic [15:0] rd_data // Read data, frame bits 23 to 8
);

	// ------------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------------
	logic is_bank, is_toggle, is_enable, is_mux, is_fault;
	logic is_code_all, is_code_upd, is_set_all, is_set_upd, is_upd_all;
	logic is_chan_rd, is_glob_rd;
	logic [3:0] chan_idx;
	logic [DAC_BITS-1:0] code_in;

	function automatic logic hit(input logic [7:0] value);
		hit = cmd_valid && (cmd_byte == value);
	endfunction

	function automatic logic [15:0] left_justify(input logic [15:0] v,
		input int width);
		logic [15:0] r;
		r = 16'h0000;
		r = v << (16 - width);
		left_justify = r;
	endfunction

	assign is_bank = hit(dac_cmd_pkg::CMD_BANK_SELECT);
	assign is_toggle = hit(dac_cmd_pkg::CMD_SOFT_TOGGLE);
	assign is_enable = hit(dac_cmd_pkg::CMD_TOGGLE_EN);
	assign is_mux = hit(dac_cmd_pkg::CMD_MUX_CTRL);
	assign is_fault = hit(dac_cmd_pkg::CMD_FAULT);
	assign is_code_all = hit(dac_cmd_pkg::CMD_CODE_ALL);
	assign is_code_upd = hit(dac_cmd_pkg::CMD_CODE_ALL_UPD);
	assign is_set_all = hit(dac_cmd_pkg::CMD_SET_ALL);
	assign is_set_upd = hit(dac_cmd_pkg::CMD_SET_ALL_UPD);
	assign is_upd_all = hit(dac_cmd_pkg::CMD_UPDATE_ALL);
	assign chan_idx = cmd_byte[3:0];
	assign is_chan_rd = cmd_valid &&
		(cmd_byte[7:4] >= dac_cmd_pkg::CMD_RD_CODE) &&
		(cmd_byte[7:4] <= dac_cmd_pkg::CMD_RD_GAIN);
	assign is_glob_rd = cmd_valid &&
		(cmd_byte >= dac_cmd_pkg::CMD_RD_CONFIG) &&
		(cmd_byte <= dac_cmd_pkg::CMD_RD_THERMAL);
	// The 12-bit variant keeps its code in the top bits of the field.
	assign code_in = cmd_data[15 -: DAC_BITS];

	// ------------------------------------------------------------------
	// Global control registers
	// ------------------------------------------------------------------
	logic [CHANNELS-1:0] enable_q, bank_q, toggle_q;
	logic mux_on_q;
	logic [9:0] mux_sel_q;
	logic [2:0] fault_q, fault_d;

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			enable_q <= dac_cmd_pkg::RST_ENABLE[CHANNELS-1:0];
		else if (is_enable)
			enable_q <= cmd_data[CHANNELS-1:0];
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			mux_on_q <= 1'b0;
			mux_sel_q <= dac_cmd_pkg::RST_MUX_SEL;
		end
		else if (is_mux)
		begin
			mux_on_q <= cmd_data[dac_cmd_pkg::MUX_ON_BIT];
			mux_sel_q <= cmd_data[dac_cmd_pkg::MUX_SEL_LSB +:
				dac_cmd_pkg::MUX_SEL_W];
		end
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			bank_q <= '0;
			toggle_q <= '0;
		end
		else
		begin
			if (is_bank)
				bank_q <= cmd_data[CHANNELS-1:0];
			if (is_toggle)
				toggle_q <= cmd_data[CHANNELS-1:0];
		end
	end

	// A fault seen in the same cycle as a write still lands: set wins.
	always_comb
	begin
		fault_d = fault_q;
		if (is_fault)
			fault_d = cmd_data[dac_cmd_pkg::FAULT_LSB +:
				dac_cmd_pkg::FAULT_W];
		fault_d = fault_d | fault_event;
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			fault_q <= dac_cmd_pkg::RST_FAULT;
		else
			fault_q <= fault_d;
	end

	// ------------------------------------------------------------------
	// Per-channel input, DAC and settings registers
	// ------------------------------------------------------------------
	logic [DAC_BITS-1:0] in_a_q [CHANNELS];
	logic [DAC_BITS-1:0] in_b_q [CHANNELS];
	logic [DAC_BITS-1:0] dac_q [CHANNELS];
	logic [11:0] set_q [CHANNELS];
	logic [CHANNELS-1:0] upd_q;

	// Source used by a plain update: the bank the toggle bit points at
	// while toggling is on, otherwise the first bank.
	function automatic logic [DAC_BITS-1:0] upd_src(input int i);
		upd_src = (enable_q[i] && toggle_q[i]) ? in_b_q[i] : in_a_q[i];
	endfunction

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			for (int i = 0; i < CHANNELS; i++)
			begin
				in_a_q[i] <= '0;
				in_b_q[i] <= '0;
				dac_q[i] <= '0;
			end
			upd_q <= '0;
		end
		else
		begin
			upd_q <= '0;
			for (int i = 0; i < CHANNELS; i++)
			begin
				if (is_code_all || is_code_upd)
				begin
					if (bank_q[i])
						in_b_q[i] <= code_in;
					else
						in_a_q[i] <= code_in;
				end
				if (is_code_upd)
				begin
					dac_q[i] <= code_in;
					upd_q[i] <= 1'b1;
				end
				else if (is_upd_all || is_set_upd)
				begin
					dac_q[i] <= upd_src(i);
					upd_q[i] <= 1'b1;
				end
				else if (is_toggle && toggle_q[i] && !cmd_data[i])
				begin
					dac_q[i] <= in_a_q[i];
					upd_q[i] <= 1'b1;
				end
				else if (is_toggle && !toggle_q[i] && cmd_data[i])
				begin
					dac_q[i] <= in_b_q[i];
					upd_q[i] <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			for (int i = 0; i < CHANNELS; i++)
				set_q[i] <= dac_cmd_pkg::RST_SET;
		end
		else if (is_set_all || is_set_upd)
		begin
			for (int i = 0; i < CHANNELS; i++)
				set_q[i] <= cmd_data[dac_cmd_pkg::SET_W-1:0];
		end
	end

	// ------------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------------
	logic [15:0] rd_d;
	logic rd_valid_q;
	logic [15:0] rd_data_q;

	always_comb
	begin
		rd_d = 16'h0000;
		if (is_chan_rd)
		begin
			case (cmd_byte[7:4])
				dac_cmd_pkg::CMD_RD_CODE:
					rd_d = left_justify(16'(dac_q[chan_idx]), DAC_BITS);
				dac_cmd_pkg::CMD_RD_SET:
					rd_d = 16'(set_q[chan_idx]);
				dac_cmd_pkg::CMD_RD_OFFSET:
					rd_d = left_justify(16'(offset_flat[chan_idx*14 +: 14]),
						dac_cmd_pkg::OFFSET_W);
				dac_cmd_pkg::CMD_RD_GAIN:
					rd_d = left_justify(
						16'(gain_flat[chan_idx*DAC_BITS +: DAC_BITS]), DAC_BITS);
				default:
					rd_d = 16'h0000;
			endcase
		end
		else
		begin
			case (cmd_byte)
				dac_cmd_pkg::CMD_RD_CONFIG:
					rd_d = 16'(config_in);
				dac_cmd_pkg::CMD_RD_POWER:
					rd_d = 16'(power_down_in);
				dac_cmd_pkg::CMD_RD_BANK:
					rd_d = 16'(bank_q);
				dac_cmd_pkg::CMD_RD_TOGGLE:
					rd_d = 16'(toggle_q);
				dac_cmd_pkg::CMD_RD_ENABLE:
					rd_d = 16'(enable_q);
				dac_cmd_pkg::CMD_RD_MUX:
					rd_d = 16'({mux_on_q, mux_sel_q});
				dac_cmd_pkg::CMD_RD_FAULT:
					rd_d = 16'(fault_q);
				dac_cmd_pkg::CMD_RD_THERMAL:
					rd_d = 16'(thermal_status_in);
				default:
					rd_d = 16'h0000;
			endcase
		end
	end

	// No-operation and unknown bytes give no read strobe.
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			rd_valid_q <= 1'b0;
			rd_data_q <= 16'h0000;
		end
		else
		begin
			rd_valid_q <= is_chan_rd || is_glob_rd;
			if (is_chan_rd || is_glob_rd)
				rd_data_q <= rd_d;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++)
		begin : g_flat
			assign dac_code_flat[g*DAC_BITS +: DAC_BITS] = dac_q[g];
			assign settings_flat[g*12 +: 12] = set_q[g];
		end
	endgenerate

	assign toggle_dither_on = enable_q;
	assign monitor_mux_on = mux_on_q;
	assign monitor_select = mux_sel_q;
	assign thermal_shutdown_fault = fault_q[2];
	assign clock_integrity_fault = fault_q[1];
	assign command_integrity_fault = fault_q[0];
	assign input_bank_select = bank_q;
	assign soft_toggle_bit = toggle_q;
	assign dac_update = upd_q;
	assign rd_valid = rd_valid_q;
	assign rd_data = rd_data_q;

endmodule

// ---- bench/dac_cmd_props.sv ----
`timescale 1ns/1ns
module dac_cmd_props
#(
	parameter int CHANNELS = 16,
	parameter int DAC_BITS = 16
)
(
	input wire logic clock, // Clock
	input wire logic nrst, // Reset
	input wire logic cmd_valid, // Strobe
	input wire logic [7:0] cmd_byte, // Command
	input wire logic [15:0] cmd_data, // Field
	input wire logic [2:0] fault_event, // Set pulses
	input wire logic [CHANNELS-1:0] toggle_dither_on, // Enables
	input wire logic monitor_mux_on, // Mux on
	input wire logic [9:0] monitor_select, // Mux select
	input wire logic thermal_shutdown_fault, // Flag
	input wire logic clock_integrity_fault, // Flag
	input wire logic command_integrity_fault, // Flag
	input wire logic [CHANNELS*12-1:0] settings_flat, // Settings
	input wire logic [CHANNELS-1:0] dac_update, // Updates
	input wire logic rd_valid, // Read strobe
	input wire logic [15:0] rd_data // Read data
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);
	// Byte 0x00 is refused, so it stands for no command.
	logic [7:0] op;
	logic [15:0] data_q;
	logic [7:0] byte_q;
	assign op = cmd_valid ? cmd_byte : 8'h00;
	always_ff @(posedge clock)
	begin
		data_q <= cmd_data;
		byte_q <= cmd_byte;
	end
	AST_EN: assert property (op == 8'h74 |=>
		toggle_dither_on == data_q) else $error("enable mismatch");
	AST_MUX: assert property (op == 8'h75 |=>
		{monitor_mux_on, monitor_select} == data_q[10:0])
		else $error("mux mismatch");
	AST_FAULT: assert property (op == 8'h76 && fault_event == 3'h0 |=>
		{thermal_shutdown_fault, clock_integrity_fault,
		command_integrity_fault} == data_q[2:0]) else $error("fault");
	AST_NOUPD: assert property (op == 8'h78 |=> dac_update == '0)
		else $error("update on code load");
	AST_UPD: assert property (op == 8'h79 || op == 8'h7c |=>
		dac_update == '1) else $error("no update");
	AST_SET: assert property (op == 8'h7a |=> dac_update == '0 &&
		settings_flat == {CHANNELS{data_q[11:0]}}) else $error("settings");
	AST_SETU: assert property (op == 8'h7b |=> dac_update == '1 &&
		settings_flat == {CHANNELS{data_q[11:0]}}) else $error("set upd");
	AST_RDCH: assert property (op[7:4] == 4'h9 |=> rd_valid &&
		rd_data[11:0] == settings_flat[byte_q[3:0]*12+:12])
		else $error("channel read");
	AST_RDEN: assert property (op == 8'hf4 |=> rd_valid &&
		rd_data == toggle_dither_on) else $error("enable read");
	AST_NOP: assert property (op == 8'hff |=> !rd_valid &&
		dac_update == '0) else $error("no-op acted");
	cover property (op == 8'h79);
	cover property (op == 8'h73 ##1 dac_update != '0);
	cover property (rd_valid);
endmodule

// ---- bench/dac_host.sv ----
`timescale 1ns/1ns
module dac_host
(
	input wire logic clock, // Clock
	output logic cmd_valid, // Strobe
	output logic [7:0] cmd_byte, // Command
	output logic [15:0] cmd_data // Field
);
	initial
	begin
		cmd_valid = 1'b0;
		cmd_byte = 8'h00;
		cmd_data = 16'h0000;
	end
	task automatic send(input logic [7:0] b, input logic [15:0] d);
		@(posedge clock);
		#2;
		cmd_valid = 1'b1;
		cmd_byte = b;
		cmd_data = d;
	endtask
	// Released fields flip so a stale value can never look valid.
	task automatic idle();
		@(posedge clock);
		#2;
		cmd_valid = 1'b0;
		cmd_byte = ~cmd_byte;
		cmd_data = ~cmd_data;
	endtask
	task automatic chan(input logic [3:0] code, input logic [3:0] ch);
		send({code, ch}, 16'h0000);
	endtask
endmodule

// ---- bench/dac_broadcast_command_decoder_tb_top.sv ----
`timescale 1ns/1ns
module dac_broadcast_command_decoder_tb_top;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic cmd_valid, rd_valid, mon_on, f_t, f_c, f_m;
	logic [7:0] cmd_byte;
	logic [15:0] cmd_data, rd_data, ten, bank, tog, upd;
	logic [2:0] fault_event = 3'h0;
	logic [9:0] mon_sel;
	logic [223:0] offset_flat;
	logic [255:0] gain_flat, dac;
	logic [191:0] sets;
	int failures = 0;
	int compares = 0;
	int cycles = 0;
	always #20 clock = ~clock;
	dac_host host (.clock(clock), .cmd_valid(cmd_valid),
		.cmd_byte(cmd_byte), .cmd_data(cmd_data));
	dac_broadcast_command_decoder DUT (.clock(clock), .nrst(nrst),
		.cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .cmd_data(cmd_data),
		.config_in(3'h5), .power_down_in(16'h8421),
		.thermal_status_in(16'h0f0f), .fault_event(fault_event),
		.offset_flat(offset_flat), .gain_flat(gain_flat),
		.toggle_dither_on(ten), .monitor_mux_on(mon_on),
		.monitor_select(mon_sel), .thermal_shutdown_fault(f_t),
		.clock_integrity_fault(f_c), .command_integrity_fault(f_m),
		.input_bank_select(bank), .soft_toggle_bit(tog),
		.dac_code_flat(dac), .settings_flat(sets), .dac_update(upd),
		.rd_valid(rd_valid), .rd_data(rd_data));
	task automatic summarize();
		if (failures == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [271:0] got, input logic [271:0] exp);
		compares++;
		if (got !== exp)
		begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmd(input logic [7:0] b, input logic [15:0] d);
		host.send(b, d);
		host.idle();
	endtask
	task automatic rd(input logic [7:0] b, input logic [15:0] exp);
		cmd(b, 16'h0000);
		chk(rd_valid, 1'b1);
		chk(rd_data, exp);
	endtask
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			failures++;
			summarize();
		end
	end
	initial
	begin
		for (int i = 0; i < 16; i++)
		begin
			gain_flat[i*16+:16] = 16'h1000 + 16'(i);
			offset_flat[i*14+:14] = 14'h0100 + 14'(i);
		end
		repeat (2) @(posedge clock);
		#2 nrst = 1'b1;
		chk({mon_on, mon_sel, f_t, f_c, f_m, ten}, 0);
		cmd(8'h74, 16'ha5c3);
		chk(ten, 16'ha5c3);
		rd(8'hf4, 16'ha5c3);
		cmd(8'h74, 16'h0000);
		chk(ten, 16'h0000);
		cmd(8'h75, 16'h07ff);
		chk({mon_on, mon_sel}, 11'h7ff);
		rd(8'hf5, 16'h07ff);
		cmd(8'h75, 16'h0155);
		chk({mon_on, mon_sel}, 11'h155);
		cmd(8'h76, 16'h0005);
		chk({f_t, f_c, f_m}, 3'h5);
		rd(8'hf6, 16'h0005);
		@(posedge clock);
		#2 fault_event = 3'h2;
		@(posedge clock);
		#2 fault_event = 3'h0;
		chk({f_t, f_c, f_m}, 3'h7);
		cmd(8'h76, 16'h0000);
		chk({f_t, f_c, f_m}, 3'h0);
		cmd(8'h78, 16'h1234);
		chk({upd, dac}, 0);
		cmd(8'h7c, 16'h0000);
		chk({upd, dac}, {16'hffff, {16{16'h1234}}});
		cmd(8'h79, 16'habcd);
		chk({upd, dac}, {16'hffff, {16{16'habcd}}});
		cmd(8'h7a, 16'h0abc);
		chk({upd, sets}, {16'h0000, {16{12'habc}}});
		cmd(8'h7b, 16'h0123);
		chk({upd, sets}, {16'hffff, {16{12'h123}}});
		rd(8'h93, 16'h0123);
		rd(8'ha5, {14'h0105, 2'b00});
		rd(8'hb2, 16'h1002);
		rd(8'h87, 16'habcd);
		rd(8'hf0, 16'h0005);
		rd(8'hf1, 16'h8421);
		rd(8'hf7, 16'h0f0f);
		cmd(8'h72, 16'h0001);
		chk(bank, 16'h0001);
		cmd(8'h78, 16'h5555);
		rd(8'hf2, 16'h0001);
		cmd(8'h73, 16'h0001);
		chk({upd, dac[15:0]}, {16'h0001, 16'h5555});
		chk(tog, 16'h0001);
		rd(8'hf3, 16'h0001);
		cmd(8'h73, 16'h0000);
		chk({upd, dac[15:0]}, {16'h0001, 16'habcd});
		host.send(8'h74, 16'h00f0);
		host.send(8'hf4, 16'h0000);
		host.idle();
		chk({rd_valid, rd_data}, {1'b1, 16'h00f0});
		cmd(8'h72, 16'h0000);
		cmd(8'h78, 16'h1357);
		cmd(8'h74, 16'h0001);
		cmd(8'h73, 16'h0001);
		cmd(8'h7c, 16'h0000);
		chk({upd, dac[31:0]}, {16'hffff, 16'h1357, 16'h5555});
		cmd(8'hff, 16'h0000);
		chk({rd_valid, upd}, 0);
		summarize();
	end
endmodule
bind dac_broadcast_command_decoder dac_cmd_props #(.CHANNELS(CHANNELS),
	.DAC_BITS(DAC_BITS)) props (.clock(clock), .nrst(nrst),
	.cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .cmd_data(cmd_data),
	.fault_event(fault_event), .toggle_dither_on(toggle_dither_on),
	.monitor_mux_on(monitor_mux_on), .monitor_select(monitor_select),
	.thermal_shutdown_fault(thermal_shutdown_fault),
	.clock_integrity_fault(clock_integrity_fault),
	.command_integrity_fault(command_integrity_fault),
	.settings_flat(settings_flat), .dac_update(dac_update),
	.rd_valid(rd_valid), .rd_data(rd_data));
